/* shared/clk_status_pkg.sv */
// Constants, register map and types of the clock status and interrupt block.
// Assumes an APB master with 32-bit data and byte addressing.
package clk_status_pkg;

   // ---------------------------------------------------------------
   // Bus and map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int N_IN = 2;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_IE_A = 10'h068;
   localparam logic [9:0] IDX_IE_B = 10'h069;
   localparam logic [9:0] IDX_LS_A = 10'h06c;
   localparam logic [9:0] IDX_ST_A = 10'h06d;
   localparam logic [9:0] IDX_LS_B = 10'h06e;
   localparam logic [9:0] IDX_ST_B = 10'h06f;
   localparam logic [ADDR_W-1:0] ADR_IE_A = {IDX_IE_A, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_IE_B = {IDX_IE_B, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_LS_A = {IDX_LS_A, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_ST_A = {IDX_ST_A, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_LS_B = {IDX_LS_B, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_ST_B = {IDX_ST_B, 2'h0};

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_FINE = 5;
   localparam int BIT_VCXO = 4;
   localparam int BIT_IN0 = 0;
   localparam int BIT_REF = 1;
   localparam int BIT_HOLD = 0;
   localparam int BIT_CAL = 2;
   localparam int SEL_LSB = 6;

   // ---------------------------------------------------------------
   // Live status word
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] sel;
      logic fine_n;
      logic vcxo_n;
      logic [N_IN-1:0] act;
      logic ref_ok;
      logic hold_n;
      logic cal_busy;
   } live_t;

   localparam int LIVE_W = $bits(live_t);
   // Healthy status assumed until the first samples arrive
   localparam live_t LIVE_RST = '{sel: 2'h0, fine_n: 1'b1, vcxo_n: 1'b1, act: 2'h3,
                                  ref_ok: 1'b1, hold_n: 1'b1, cal_busy: 1'b0};
   localparam logic STICKY_RST = 1'b1;
   localparam logic IE_RST = 1'b0;
   localparam logic IRQ_N_RST = 1'b1;

endpackage : clk_status_pkg

/* shared/live_status_if.sv */
// Carrier of synchronised live status between synchroniser and register logic.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface live_status_if;
   clk_status_pkg::live_t live;
   modport src (output live);
   modport snk (input live);
endinterface : live_status_if
`default_nettype wire

/* hdl/status_sync.sv */
// Three-stage synchroniser for the live status word from PLL and monitor domains.
// Assumes raw inputs are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module status_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire clk_status_pkg::live_t raw,
   live_status_if.src out
);

   typedef struct packed {
      logic [clk_status_pkg::LIVE_W-1:0] s1;
      logic [clk_status_pkg::LIVE_W-1:0] s2;
      logic [clk_status_pkg::LIVE_W-1:0] s3;
      logic [clk_status_pkg::LIVE_W-1:0] val;
   } sync_t;

   sync_t q;
   sync_t d;
   logic [clk_status_pkg::LIVE_W-1:0] agreed;

   // ---------------------------------------------------------------
   // Accept a change once stages two and three agree
   // ---------------------------------------------------------------
   for (genvar i = 0; i < clk_status_pkg::LIVE_W; i++) begin : g_bit
      assign agreed[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.val[i]; // [R20]
   end

   always_comb begin
      d = q;
      d.s1 = raw;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.val = agreed;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{s1: clk_status_pkg::LIVE_RST, s2: clk_status_pkg::LIVE_RST,
                s3: clk_status_pkg::LIVE_RST, val: clk_status_pkg::LIVE_RST};
      end else begin
         q <= d;
      end
   end

   assign out.live = q.val;

endmodule : status_sync
`default_nettype wire

/* hdl/clock_status_interrupt_logic.sv */
// Status latches, interrupt enables and active-low interrupt of a dual-PLL synthesizer.
// Assumes an APB master on pclk; live status arrives from other clock domains.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Fine PLL unlock latch interrupts when enabled
// R2 - VCXO PLL unlock latch interrupts when enabled
// R3 - Per-input LOS latch interrupts when enabled
// R4 - Reference latch change interrupts when enabled
// R5 - Holdover latch interrupts when enabled
// R6 - Fine unlock latch, write one clears
// R7 - VCXO unlock latch, write one clears
// R8 - Input LOS latches, write one clears
// R9 - Reference valid latch, write one clears
// R10 - Holdover latch, write one clears
// R11 - Selected input shown read-only
// R12 - Live fine lock bit feeds latch
// R13 - Live VCXO lock bit feeds latch
// R14 - Live input activity feeds latches
// R15 - Fine PLL calibration busy readable
// R16 - Live reference present feeds latch
// R17 - Live not-holdover bit feeds latch
// R18 - Unlock and LOS enables share one register
// R19 - Interrupt is OR of enabled pending
// R20 - Live inputs synchronised before latching
module clock_status_interrupt_logic (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [clk_status_pkg::ADDR_W-1:0] paddr,
   input wire logic [clk_status_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [clk_status_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] selected_input_in,
   input wire logic fine_pll_locked_n_in,
   input wire logic vcxo_pll_locked_n_in,
   input wire logic [clk_status_pkg::N_IN-1:0] input_active_in,
   input wire logic ref_present_in,
   input wire logic not_holdover_in,
   input wire logic fine_pll_cal_busy_in,
   output logic irq_out_low
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic irq_en_fine_pll_unlock;
      logic irq_en_vcxo_pll_unlock;
      logic [clk_status_pkg::N_IN-1:0] irq_en_input_los;
      logic irq_en_ref_change;
      logic irq_en_holdover;
      logic sticky_fine_pll_locked_n;
      logic sticky_vcxo_pll_locked_n;
      logic [clk_status_pkg::N_IN-1:0] sticky_input_active;
      logic sticky_ref_valid;
      logic sticky_not_holdover;
      logic ref_pend;
      logic irq_n;
      logic [clk_status_pkg::DATA_W-1:0] rdata;
   } state_t;

   state_t q;
   state_t d;
   clk_status_pkg::live_t raw;
   live_status_if sync_bus ();

   // ---------------------------------------------------------------
   // Live status synchronisation
   // ---------------------------------------------------------------
   always_comb begin
      raw.sel = selected_input_in;
      raw.fine_n = fine_pll_locked_n_in;
      raw.vcxo_n = vcxo_pll_locked_n_in;
      raw.act = input_active_in;
      raw.ref_ok = ref_present_in;
      raw.hold_n = not_holdover_in;
      raw.cal_busy = fine_pll_cal_busy_in;
   end

   status_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .raw(raw),
      .out(sync_bus.src)
   ); // [R20]

   clk_status_pkg::live_t live;
   assign live = sync_bus.live;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic access;
   logic wr;
   logic hit;
   logic wr_ie_a;
   logic wr_ie_b;
   logic wr_ls_a;
   logic wr_ls_b;
   logic clr_fine;
   logic clr_vcxo;
   logic [clk_status_pkg::N_IN-1:0] clr_in;
   logic clr_ref;
   logic clr_hold;
   logic [clk_status_pkg::N_IN-1:0] los_pend;
   logic any_pend;

   assign access = psel && penable;
   assign hit = (paddr == clk_status_pkg::ADR_IE_A) || (paddr == clk_status_pkg::ADR_IE_B) ||
                (paddr == clk_status_pkg::ADR_LS_A) || (paddr == clk_status_pkg::ADR_ST_A) ||
                (paddr == clk_status_pkg::ADR_LS_B) || (paddr == clk_status_pkg::ADR_ST_B);
   assign wr = access && pwrite && pstrb[0];
   assign wr_ie_a = wr && (paddr == clk_status_pkg::ADR_IE_A);
   assign wr_ie_b = wr && (paddr == clk_status_pkg::ADR_IE_B);
   assign wr_ls_a = wr && (paddr == clk_status_pkg::ADR_LS_A);
   assign wr_ls_b = wr && (paddr == clk_status_pkg::ADR_LS_B);
   assign clr_fine = wr_ls_a && pwdata[clk_status_pkg::BIT_FINE];
   assign clr_vcxo = wr_ls_a && pwdata[clk_status_pkg::BIT_VCXO];
   assign clr_in = wr_ls_a ? pwdata[clk_status_pkg::BIT_IN0 +: clk_status_pkg::N_IN] : '0;
   assign clr_ref = wr_ls_b && pwdata[clk_status_pkg::BIT_REF];
   assign clr_hold = wr_ls_b && pwdata[clk_status_pkg::BIT_HOLD];

   // ---------------------------------------------------------------
   // Pending events
   // ---------------------------------------------------------------
   assign los_pend = q.irq_en_input_los & ~q.sticky_input_active; // [R3]
   assign any_pend = (q.irq_en_fine_pll_unlock && !q.sticky_fine_pll_locked_n) || // [R1]
                     (q.irq_en_vcxo_pll_unlock && !q.sticky_vcxo_pll_locked_n) || // [R2]
                     (|los_pend) ||
                     (q.irq_en_ref_change && q.ref_pend) || // [R4]
                     (q.irq_en_holdover && !q.sticky_not_holdover); // [R5]

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      if (wr_ie_a) begin
         d.irq_en_fine_pll_unlock = pwdata[clk_status_pkg::BIT_FINE]; // [R18]
         d.irq_en_vcxo_pll_unlock = pwdata[clk_status_pkg::BIT_VCXO];
         d.irq_en_input_los = pwdata[clk_status_pkg::BIT_IN0 +: clk_status_pkg::N_IN];
      end
      if (wr_ie_b) begin
         d.irq_en_ref_change = pwdata[clk_status_pkg::BIT_REF];
         d.irq_en_holdover = pwdata[clk_status_pkg::BIT_HOLD];
      end
      // Latches: event wins over a clear in the same cycle
      d.sticky_fine_pll_locked_n = (q.sticky_fine_pll_locked_n || clr_fine) && live.fine_n; // [R6] [R12]
      d.sticky_vcxo_pll_locked_n = (q.sticky_vcxo_pll_locked_n || clr_vcxo) && live.vcxo_n; // [R7] [R13]
      d.sticky_input_active = (q.sticky_input_active | clr_in) & live.act; // [R8] [R14]
      d.sticky_ref_valid = (q.sticky_ref_valid || clr_ref) && live.ref_ok; // [R9] [R16]
      d.sticky_not_holdover = (q.sticky_not_holdover || clr_hold) && live.hold_n; // [R10] [R17]
      // Reference latch change marks its own pending event
      d.ref_pend = (q.ref_pend && !clr_ref) ||
                   ((q.sticky_ref_valid || clr_ref) && !live.ref_ok); // [R4]
      d.irq_n = !any_pend; // [R19]
      // Read data captured in the setup phase
      if (psel && !penable) begin
         d.rdata = '0;
         unique case (paddr)
            clk_status_pkg::ADR_IE_A: begin
               d.rdata[clk_status_pkg::BIT_FINE] = q.irq_en_fine_pll_unlock;
               d.rdata[clk_status_pkg::BIT_VCXO] = q.irq_en_vcxo_pll_unlock;
               d.rdata[clk_status_pkg::BIT_IN0 +: clk_status_pkg::N_IN] = q.irq_en_input_los;
            end
            clk_status_pkg::ADR_IE_B: begin
               d.rdata[clk_status_pkg::BIT_REF] = q.irq_en_ref_change;
               d.rdata[clk_status_pkg::BIT_HOLD] = q.irq_en_holdover;
            end
            clk_status_pkg::ADR_LS_A: begin
               d.rdata[clk_status_pkg::BIT_FINE] = q.sticky_fine_pll_locked_n;
               d.rdata[clk_status_pkg::BIT_VCXO] = q.sticky_vcxo_pll_locked_n;
               d.rdata[clk_status_pkg::BIT_IN0 +: clk_status_pkg::N_IN] = q.sticky_input_active;
            end
            clk_status_pkg::ADR_ST_A: begin
               d.rdata[clk_status_pkg::SEL_LSB +: 2] = live.sel; // [R11]
               d.rdata[clk_status_pkg::BIT_FINE] = live.fine_n; // [R12]
               d.rdata[clk_status_pkg::BIT_VCXO] = live.vcxo_n; // [R13]
               d.rdata[clk_status_pkg::BIT_IN0 +: clk_status_pkg::N_IN] = live.act; // [R14]
            end
            clk_status_pkg::ADR_LS_B: begin
               d.rdata[clk_status_pkg::BIT_REF] = q.sticky_ref_valid;
               d.rdata[clk_status_pkg::BIT_HOLD] = q.sticky_not_holdover;
            end
            clk_status_pkg::ADR_ST_B: begin
               d.rdata[clk_status_pkg::BIT_CAL] = live.cal_busy; // [R15]
               d.rdata[clk_status_pkg::BIT_REF] = live.ref_ok; // [R16]
               d.rdata[clk_status_pkg::BIT_HOLD] = live.hold_n; // [R17]
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{irq_en_fine_pll_unlock: clk_status_pkg::IE_RST,
                irq_en_vcxo_pll_unlock: clk_status_pkg::IE_RST,
                irq_en_input_los: {clk_status_pkg::N_IN{clk_status_pkg::IE_RST}},
                irq_en_ref_change: clk_status_pkg::IE_RST,
                irq_en_holdover: clk_status_pkg::IE_RST,
                sticky_fine_pll_locked_n: clk_status_pkg::STICKY_RST,
                sticky_vcxo_pll_locked_n: clk_status_pkg::STICKY_RST,
                sticky_input_active: {clk_status_pkg::N_IN{clk_status_pkg::STICKY_RST}},
                sticky_ref_valid: clk_status_pkg::STICKY_RST,
                sticky_not_holdover: clk_status_pkg::STICKY_RST,
                ref_pend: 1'b0,
                irq_n: clk_status_pkg::IRQ_N_RST,
                rdata: '0};
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = q.rdata;
   assign pready = access;
   assign pslverr = access && !hit;
   assign irq_out_low = q.irq_n;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Setup-phase reads of the live status words
   logic setup_st_a;
   logic setup_st_b;
   assign setup_st_a = psel && !penable && (paddr == clk_status_pkg::ADR_ST_A);
   assign setup_st_b = psel && !penable && (paddr == clk_status_pkg::ADR_ST_B);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence clear_fine_s;
      wr_ls_a && pwdata[clk_status_pkg::BIT_FINE] && live.fine_n;
   endsequence

   sequence fine_lost_s;
      !live.fine_n ##1 !q.sticky_fine_pll_locked_n;
   endsequence

   sequence ref_lost_s;
      !live.ref_ok ##1 !q.sticky_ref_valid;
   endsequence

   fine_irq_a: assert property (q.irq_en_fine_pll_unlock && !q.sticky_fine_pll_locked_n |=> !irq_out_low) // [R1]
      else $error("fine unlock did not raise interrupt");
   vcxo_irq_a: assert property (q.irq_en_vcxo_pll_unlock && !q.sticky_vcxo_pll_locked_n |=> !irq_out_low) // [R2]
      else $error("vcxo unlock did not raise interrupt");
   los_irq_a: assert property (|(q.irq_en_input_los & ~q.sticky_input_active) |=> !irq_out_low) // [R3]
      else $error("input loss did not raise interrupt");
   ref_irq_a: assert property ($fell(q.sticky_ref_valid) && q.irq_en_ref_change |=> !irq_out_low) // [R4]
      else $error("reference change did not raise interrupt");
   hold_irq_a: assert property (q.irq_en_holdover && !q.sticky_not_holdover |=> !irq_out_low) // [R5]
      else $error("holdover did not raise interrupt");
   fine_latch_a: assert property (!live.fine_n |=> !q.sticky_fine_pll_locked_n) // [R6]
      else $error("fine unlock latch not set");
   fine_clear_a: assert property (clear_fine_s |=> q.sticky_fine_pll_locked_n) // [R6]
      else $error("fine latch not cleared");
   vcxo_latch_a: assert property (!live.vcxo_n |=> !q.sticky_vcxo_pll_locked_n) // [R7]
      else $error("vcxo unlock latch not set");
   input_latch_a: assert property (!live.act[0] |=> !q.sticky_input_active[0]) // [R8]
      else $error("input loss latch not set");
   ref_latch_a: assert property (!live.ref_ok |=> !q.sticky_ref_valid ##0 q.ref_pend) // [R9]
      else $error("reference latch not set");
   hold_latch_a: assert property (!live.hold_n [*2] |=> !q.sticky_not_holdover) // [R10]
      else $error("holdover latch not set");
   irq_release_a: assert property (!any_pend |=> irq_out_low) // [R19]
      else $error("interrupt held without enabled event");
   fine_seq_irq_a: assert property (fine_lost_s ##0 q.irq_en_fine_pll_unlock |=> !irq_out_low) // [R1]
      else $error("enabled fine unlock did not interrupt");
   ref_seq_irq_a: assert property (ref_lost_s ##0 q.irq_en_ref_change |=> !irq_out_low) // [R4]
      else $error("enabled reference loss did not interrupt");
   input1_latch_a: assert property (!live.act[1] |=> !q.sticky_input_active[1]) // [R8]
      else $error("second input loss latch not set");

   // Clears only take hold once the input is healthy again
   vcxo_clear_a: assert property (clr_vcxo && live.vcxo_n |=> q.sticky_vcxo_pll_locked_n) // [R7]
      else $error("vcxo latch not cleared");
   input_clear_a: assert property (clr_in[0] && live.act[0] |=> q.sticky_input_active[0]) // [R8]
      else $error("input loss latch not cleared");
   ref_clear_a: assert property (clr_ref && live.ref_ok |=> q.sticky_ref_valid && !q.ref_pend) // [R9]
      else $error("reference latch not cleared");
   hold_clear_a: assert property (clr_hold && live.hold_n |=> q.sticky_not_holdover) // [R10]
      else $error("holdover latch not cleared");
   ie_write_a: assert property (wr_ie_a |=> // [R18]
      q.irq_en_fine_pll_unlock == $past(pwdata[clk_status_pkg::BIT_FINE]))
      else $error("enable write not taken");

   // Live words are captured in the setup cycle
   sel_read_a: assert property (setup_st_a |=> prdata[clk_status_pkg::SEL_LSB +: 2] == $past(live.sel)) // [R11]
      else $error("selected input not shown");
   fine_read_a: assert property (setup_st_a |=> prdata[clk_status_pkg::BIT_FINE] == $past(live.fine_n)) // [R12]
      else $error("live fine lock not shown");
   cal_read_a: assert property (setup_st_b |=> prdata[clk_status_pkg::BIT_CAL] == $past(live.cal_busy)) // [R15]
      else $error("calibration busy not shown");
   hold_read_a: assert property (setup_st_b |=> prdata[clk_status_pkg::BIT_HOLD] == $past(live.hold_n)) // [R17]
      else $error("live holdover not shown");

endmodule : clock_status_interrupt_logic
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the clock status and interrupt block.
// Assumes the design carries its own assertions; APB master and live inputs driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   typedef struct packed {logic wr; logic err; logic [31:0] data;} note_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [clk_status_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] sel = 2'h0;
   logic cal = 1'b0;
   logic [5:0] lv = 6'h3f;
   logic irq_out_low;
   note_t notes[$];
   note_t n;
   int err_total = 0;
   int comparisons = 0;

   always #4 pclk = ~pclk;

   clock_status_interrupt_logic i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .selected_input_in(sel), .fine_pll_locked_n_in(lv[0]),
      .vcxo_pll_locked_n_in(lv[1]), .input_active_in(lv[3:2]), .ref_present_in(lv[4]),
      .not_holdover_in(lv[5]), .fine_pll_cal_busy_in(cal), .irq_out_low(irq_out_low)
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk

   task conclude;
      $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic e);
      int k;
      notes.push_back('{wr: wr, err: e, data: d});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wr ? d : 32'h0;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, exp, 4'hf, 1'b0);
   endtask : rd

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf, 1'b0);
   endtask : wr

   task irq(input logic exp, input int cyc);
      repeat (cyc) @(posedge pclk);
      // Look between edges, where the registered output has settled
      @(negedge pclk);
      chk("irq_out_low", {31'h0, exp}, {31'h0, irq_out_low});
      @(posedge pclk);
   endtask : irq

   // ------------------------------------------------------------
   // Result monitor
   // ------------------------------------------------------------
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (notes.size() == 0) begin
            chk("note queue", 32'h1, 32'h0);
         end else begin
            n = notes.pop_front();
            chk("pslverr", {31'h0, n.err}, {31'h0, pslverr});
            if (!n.wr) begin
               chk("prdata", n.data, prdata);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge pclk);
      $display("[ERR] watchdog expected end seen hang");
      err_total++;
      conclude();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [11:0] a_ie, a_ls, a_st;
      logic [31:0] base, m;
      int b;
      int bp[6];
      bp = '{clk_status_pkg::BIT_FINE, clk_status_pkg::BIT_VCXO, clk_status_pkg::BIT_IN0,
             clk_status_pkg::BIT_IN0 + 1, clk_status_pkg::BIT_REF, clk_status_pkg::BIT_HOLD};
      void'($urandom(32'hecfc));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, reserved bits, unmapped and read-only places
      rd(clk_status_pkg::ADR_IE_A, 32'h0);
      rd(clk_status_pkg::ADR_IE_B, 32'h0);
      rd(clk_status_pkg::ADR_LS_A, 32'h33);
      rd(clk_status_pkg::ADR_LS_B, 32'h03);
      rd(clk_status_pkg::ADR_ST_B, 32'h03);
      apb(1'b0, 12'h000, 32'h0, 4'hf, 1'b1);
      apb(1'b1, clk_status_pkg::ADR_IE_A, 32'hff, 4'h0, 1'b0);
      rd(clk_status_pkg::ADR_IE_A, 32'h0);
      wr(clk_status_pkg::ADR_IE_A, 32'hff);
      rd(clk_status_pkg::ADR_IE_A, 32'h33);
      wr(clk_status_pkg::ADR_IE_B, 32'hff);
      rd(clk_status_pkg::ADR_IE_B, 32'h03);
      wr(clk_status_pkg::ADR_IE_A, 32'h0);
      wr(clk_status_pkg::ADR_IE_B, 32'h0);
      wr(clk_status_pkg::ADR_ST_A, 32'h0);
      rd(clk_status_pkg::ADR_ST_A, 32'h33);
      irq(1'b1, 2);
      // Each event: latch, live view, masked, set-wins clear, enable, clear
      for (int e = 0; e < 6; e++) begin
         b = bp[e];
         m = 32'h1 << b;
         a_ie = (e < 4) ? clk_status_pkg::ADR_IE_A : clk_status_pkg::ADR_IE_B;
         a_ls = (e < 4) ? clk_status_pkg::ADR_LS_A : clk_status_pkg::ADR_LS_B;
         a_st = (e < 4) ? clk_status_pkg::ADR_ST_A : clk_status_pkg::ADR_ST_B;
         base = (e < 4) ? 32'h33 : 32'h03;
         @(posedge pclk);
         lv[e] <= 1'b0;
         repeat (8) @(posedge pclk);
         rd(a_ls, base & ~m);
         rd(a_st, base & ~m);
         irq(1'b1, 1);
         wr(a_ls, m);
         rd(a_ls, base & ~m);
         wr(a_ie, m);
         irq(1'b0, 3);
         @(posedge pclk);
         lv[e] <= 1'b1;
         irq(1'b0, 8);
         rd(a_st, base);
         wr(a_ie, 32'h0);
         irq(1'b1, 3);
         wr(a_ie, m);
         irq(1'b0, 3);
         wr(a_ls, m);
         irq(1'b1, 3);
         rd(a_ls, base);
         // Enabled before the event: latch and interrupt together
         lv[e] <= 1'b0;
         irq(1'b0, 8);
         lv[e] <= 1'b1;
         irq(1'b0, 8);
         wr(a_ls, m);
         irq(1'b1, 3);
         wr(a_ie, 32'h0);
      end
      // Random selection code and calibration state
      for (int i = 0; i < 8; i++) begin
         @(posedge pclk);
         sel <= {1'b0, 1'($urandom % 2)};
         cal <= 1'($urandom % 2);
         repeat (6) @(posedge pclk);
         rd(clk_status_pkg::ADR_ST_A, {24'h0, sel, 6'h33});
         rd(clk_status_pkg::ADR_ST_B, {29'h0, cal, 2'h3});
      end
      // Reset in mid-run with a pending enabled event
      wr(clk_status_pkg::ADR_IE_A, 32'h20);
      @(posedge pclk);
      lv[0] <= 1'b0;
      irq(1'b0, 8);
      presetn <= 1'b0;
      irq(1'b1, 3);
      lv[0] <= 1'b1;
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(clk_status_pkg::ADR_IE_A, 32'h0);
      rd(clk_status_pkg::ADR_LS_A, 32'h33);
      repeat (3) @(posedge pclk);
      chk("open notes", 32'h0, notes.size());
      conclude();
   end
endmodule : tb_top
`default_nettype wire
